// *** mgh_glue.sv ***
/*
  host glue for several graphics coprocessors on one cpu bus: strap driving,
  address latch, broadcast chip selects, combined ready and master arbitration.
  assumes cpu strobes and address come from logic on sys_clk; every coprocessor
  output is asynchronous and is synchronised here.
*/
// What this block does
// [RULE_01] coprocessor picks asynchronous mode when strap low at reset fall.
// [RULE_02] glue holds byte high enable strap low throughout reset.
// [RULE_03] cpu clock and coprocessor clock are independent, unknown phase.
// [RULE_04] asynchronous slave access costs at least one extra wait state.
// [RULE_05] glue latches cpu address because cpu drops it at strobe.
// [RULE_06] cpu ready derived from slave enables, delayed through flip-flops.
// [RULE_07] cpu-writable select port, one bit per coprocessor, zero enables.
// [RULE_08] writes chip-select every enabled coprocessor together.
// [RULE_09] broadcast write completes only after every selected one is ready.
// [RULE_10] reads select only the highest priority enabled coprocessor.
// [RULE_11] broadcast scheme permits slave accesses only, no master mode; glue only blocks a new request in MGH_A_IDLE, a grant asked or held stays.
// [RULE_12] arbiter gives host bus to one coprocessor by priority on grant.
// [RULE_13] grant kept until owner drops its hold request, then re-evaluated.
`timescale 1ns/1ns
`default_nettype none

// two flip-flop synchroniser for a vector of independent levels
module mgh_sync #(
  parameter int W = 1
) (
  input  wire logic         sys_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_q;
  logic [W-1:0] sync_q;

  // first stage feeds only the second stage
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= d;
      sync_q <= meta_q;
    end
  end

  assign q = sync_q;
endmodule : mgh_sync

module mgh_glue (
  input  wire logic                         sys_clk,
  input  wire logic                         reset,
  // cpu side
  input  wire logic                         cpu_addr_strobe,
  input  wire logic [mgh_pkg::ADDR_W-1:0]   cpu_addr,
  input  wire logic                         cpu_byte_high,
  input  wire logic                         cpu_rd,
  input  wire logic                         cpu_wr,
  input  wire logic [mgh_pkg::DATA_W-1:0]   cpu_wdata,
  output logic      [mgh_pkg::DATA_W-1:0]   cpu_rdata,
  output logic                              async_ready_input,
  input  wire logic                         sel_port_wr,
  input  wire logic [mgh_pkg::N_COP-1:0]    sel_port_wdata,
  output logic      [mgh_pkg::N_COP-1:0]    sel_port_q,
  input  wire logic                         broadcast_mode,
  output logic                              host_hold_req,
  input  wire logic                         host_hold_grant,
  // coprocessor side
  output logic      [mgh_pkg::ADDR_W-1:0]   cop_addr,
  output logic      [mgh_pkg::DATA_W-1:0]   cop_wdata,
  input  wire logic [mgh_pkg::DATA_W-1:0]   cop_rdata,
  output logic      [mgh_pkg::N_COP-1:0]    cop_cs_n,
  output logic                              cop_rd_n,
  output logic                              cop_wr_n,
  output logic                              byte_high_enable_strap_o,
  output logic                              byte_high_enable_strap_oe,
  input  wire logic [mgh_pkg::N_COP-1:0]    slave_enable_out,
  input  wire logic [mgh_pkg::N_COP-1:0]    cop_hold_req,
  output logic      [mgh_pkg::N_COP-1:0]    cop_hold_grant
);

  logic [mgh_pkg::N_COP-1:0]  slv_en_s;
  logic [mgh_pkg::N_COP-1:0]  hreq_s;
  logic                       hgnt_s;
  logic [mgh_pkg::DATA_W-1:0] rdata_s;

  // every coprocessor output crosses from its own clock
  mgh_sync #(.W(mgh_pkg::N_COP)) u_slv_en_sync (         // RULE_03
    .sys_clk (sys_clk),
    .reset   (reset),
    .d       (slave_enable_out),
    .q       (slv_en_s)
  );
  mgh_sync #(.W(mgh_pkg::N_COP)) u_hreq_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .d       (cop_hold_req),
    .q       (hreq_s)
  );
  mgh_sync #(.W(1)) u_hgnt_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .d       (host_hold_grant),
    .q       (hgnt_s)
  );
  // read data is stable by the time ready is given, sync only tidies the sample
  mgh_sync #(.W(mgh_pkg::DATA_W)) u_rdata_sync (
    .sys_clk (sys_clk),
    .reset   (reset),
    .d       (cop_rdata),
    .q       (rdata_s)
  );

  // lowest index wins: isolate the lowest set bit
  function automatic logic [mgh_pkg::N_COP-1:0] lowest_set(
    input logic [mgh_pkg::N_COP-1:0] v
  );
    lowest_set = v & (~v + 1'b1);
  endfunction : lowest_set

  // slave access state
  mgh_pkg::mgh_slave_t        st_q, st_d;
  logic [mgh_pkg::ADDR_W-1:0] addr_q, addr_d;
  logic                       bhi_q, bhi_d;
  logic [mgh_pkg::DATA_W-1:0] wdata_q, wdata_d;
  logic [mgh_pkg::DATA_W-1:0] rdata_q, rdata_d;
  logic [mgh_pkg::N_COP-1:0]  sel_q, sel_d;
  logic [mgh_pkg::N_COP-1:0]  target_q, target_d;
  logic [mgh_pkg::N_COP-1:0]  seen_q, seen_d;
  logic [3:0]                 cnt_q, cnt_d;
  logic                       is_wr_q, is_wr_d;
  logic                       rd_n_q, rd_n_d;
  logic                       wr_n_q, wr_n_d;
  logic                       hit;
  logic [mgh_pkg::N_COP-1:0]  enabled;

  assign hit     = (addr_q[mgh_pkg::SPACE_MSB:mgh_pkg::SPACE_LSB] == mgh_pkg::SPACE_BASE);
  assign enabled = ~sel_q;                                // RULE_07

  // next state of the slave path
  always_comb begin
    st_d     = st_q;
    addr_d   = addr_q;
    bhi_d    = bhi_q;
    wdata_d  = wdata_q;
    rdata_d  = rdata_q;
    sel_d    = sel_q;
    target_d = target_q;
    seen_d   = seen_q;
    cnt_d    = cnt_q;
    is_wr_d  = is_wr_q;
    rd_n_d   = rd_n_q;
    wr_n_d   = wr_n_q;
    // select port is written by the cpu at any time
    if (sel_port_wr) begin
      sel_d = sel_port_wdata;                             // RULE_07
    end
    case (st_q)
      mgh_pkg::MGH_S_IDLE: begin
        // cpu drops the address as the strobe falls, so hold it here
        if (cpu_addr_strobe) begin
          addr_d = cpu_addr;                              // RULE_05
          bhi_d  = cpu_byte_high;
        end
        if ((cpu_rd || cpu_wr) && hit) begin
          is_wr_d = cpu_wr;
          wdata_d = cpu_wdata;
          seen_d  = '0;
          if (cpu_wr) begin
            target_d = enabled;                           // RULE_08
          end else begin
            target_d = lowest_set(enabled);               // RULE_10
          end
          rd_n_d = cpu_wr;
          wr_n_d = ~cpu_wr;
          // nothing enabled: answer at once so the cpu never hangs
          if (((cpu_wr) ? enabled : lowest_set(enabled)) == '0) begin
            st_d = mgh_pkg::MGH_S_READY;
          end else begin
            st_d = mgh_pkg::MGH_S_WAIT;
          end
        end
      end
      mgh_pkg::MGH_S_WAIT: begin
        // enables may pulse at different times, so remember each one
        seen_d = seen_q | (slv_en_s & target_q);          // RULE_09
        if (seen_d == target_q) begin
          cnt_d = mgh_pkg::READY_DELAY_CYC;
          st_d  = mgh_pkg::MGH_S_DELAY;
        end
      end
      mgh_pkg::MGH_S_DELAY: begin
        // extra flops give read data setup and write data hold
        if (cnt_q <= 4'h1) begin                          // RULE_06
          st_d = mgh_pkg::MGH_S_READY;
        end else begin
          cnt_d = cnt_q - 4'h1;
        end
      end
      mgh_pkg::MGH_S_READY: begin
        if (!is_wr_q) begin
          rdata_d = rdata_s;
        end
        st_d = mgh_pkg::MGH_S_END;
      end
      mgh_pkg::MGH_S_END: begin
        // strobes and selects end only when the cpu ends its cycle
        if (!cpu_rd && !cpu_wr) begin
          rd_n_d   = 1'b1;
          wr_n_d   = 1'b1;
          target_d = '0;
          st_d     = mgh_pkg::MGH_S_IDLE;
        end
      end
      default: begin
        st_d = mgh_pkg::MGH_S_IDLE;
      end
    endcase
  end

  // slave path registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      st_q     <= mgh_pkg::MGH_S_IDLE;
      addr_q   <= '0;
      bhi_q    <= 1'b0;
      wdata_q  <= '0;
      rdata_q  <= '0;
      sel_q    <= mgh_pkg::SEL_RESET;
      target_q <= '0;
      seen_q   <= '0;
      cnt_q    <= 4'h0;
      is_wr_q  <= 1'b0;
      rd_n_q   <= 1'b1;
      wr_n_q   <= 1'b1;
    end else begin
      st_q     <= st_d;
      addr_q   <= addr_d;
      bhi_q    <= bhi_d;
      wdata_q  <= wdata_d;
      rdata_q  <= rdata_d;
      sel_q    <= sel_d;
      target_q <= target_d;
      seen_q   <= seen_d;
      cnt_q    <= cnt_d;
      is_wr_q  <= is_wr_d;
      rd_n_q   <= rd_n_d;
      wr_n_q   <= wr_n_d;
    end
  end

  // slave outputs; strap gated low by reset itself, so no unknown before the first edge
  assign cop_addr                  = addr_q;               // RULE_05
  assign cop_wdata                 = wdata_q;
  assign cpu_rdata                 = rdata_q;
  assign cop_cs_n                  = ~target_q;            // RULE_08
  assign cop_rd_n                  = rd_n_q;
  assign cop_wr_n                  = wr_n_q;
  assign sel_port_q                = sel_q;
  assign async_ready_input         = (st_q == mgh_pkg::MGH_S_READY);  // RULE_06
  assign byte_high_enable_strap_o  = bhi_q & ~reset;       // RULE_02
  assign byte_high_enable_strap_oe = 1'b1;                 // RULE_01

  // master mode arbitration state
  mgh_pkg::mgh_arb_t         arb_q, arb_d;
  logic [mgh_pkg::N_COP-1:0] owner_q, owner_d;
  logic                      hold_q, hold_d;
  logic [mgh_pkg::N_COP-1:0] gnt_q, gnt_d;

  // next state of the arbiter
  always_comb begin
    arb_d   = arb_q;
    owner_d = owner_q;
    hold_d  = hold_q;
    gnt_d   = gnt_q;
    case (arb_q)
      mgh_pkg::MGH_A_IDLE: begin
        // no new bus master is chosen while the broadcast scheme is on
        if (!broadcast_mode && (hreq_s != '0)) begin      // RULE_11
          owner_d = lowest_set(hreq_s);                   // RULE_12
          hold_d  = 1'b1;
          arb_d   = mgh_pkg::MGH_A_ASK;
        end
      end
      mgh_pkg::MGH_A_ASK: begin
        if ((owner_q & hreq_s) == '0) begin
          hold_d = 1'b0;
          arb_d  = mgh_pkg::MGH_A_DROP;
        end else if (hgnt_s) begin
          gnt_d = owner_q;                                // RULE_12
          arb_d = mgh_pkg::MGH_A_OWN;
        end
      end
      mgh_pkg::MGH_A_OWN: begin
        // owner keeps the bus; others stay off until it lets go
        if ((owner_q & hreq_s) == '0) begin               // RULE_13
          gnt_d  = '0;
          hold_d = 1'b0;
          arb_d  = mgh_pkg::MGH_A_DROP;
        end
      end
      mgh_pkg::MGH_A_DROP: begin
        // wait for cpu to take its grant back before choosing again
        if (!hgnt_s) begin                                // RULE_13
          owner_d = '0;
          arb_d   = mgh_pkg::MGH_A_IDLE;
        end
      end
      default: begin
        arb_d = mgh_pkg::MGH_A_IDLE;
      end
    endcase
  end

  // arbiter registers
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      arb_q   <= mgh_pkg::MGH_A_IDLE;
      owner_q <= '0;
      hold_q  <= 1'b0;
      gnt_q   <= '0;
    end else begin
      arb_q   <= arb_d;
      owner_q <= owner_d;
      hold_q  <= hold_d;
      gnt_q   <= gnt_d;
    end
  end

  assign host_hold_req  = hold_q;
  assign cop_hold_grant = gnt_q;                          // RULE_12

endmodule : mgh_glue

`default_nettype wire

// *** mgh_pkg.sv ***
/*
  constants shared by the multi graphics host glue: coprocessor count, bus widths,
  address decode, ready delay, reset values and state encodings.
  assumes a single 100 MHz sys_clk domain on the host side.
*/
`default_nettype none

package mgh_pkg;

  // structure of the attached system
  localparam int N_COP  = 4;
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;

  // coprocessor address space: top nibble of the latched address
  localparam int          SPACE_MSB  = 19;
  localparam int          SPACE_LSB  = 16;
  localparam logic [3:0]  SPACE_BASE = 4'hc;

  // clock and ready delay through flip-flops after all slave enables seen
  localparam int CLK_PERIOD_NS  = 10;
  localparam int READY_DELAY_NS = 20;
  localparam int READY_DELAY_CYC_I =
    (READY_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [3:0] READY_DELAY_CYC =
    (READY_DELAY_CYC_I < 1) ? 4'h1 : READY_DELAY_CYC_I[3:0];

  // select port resets to all ones: nothing enabled
  localparam logic [N_COP-1:0] SEL_RESET = 4'hf;

  typedef enum logic [2:0] {
    MGH_S_IDLE  = 3'b000,
    MGH_S_WAIT  = 3'b001,
    MGH_S_DELAY = 3'b010,
    MGH_S_READY = 3'b011,
    MGH_S_END   = 3'b100
  } mgh_slave_t;

  typedef enum logic [1:0] {
    MGH_A_IDLE = 2'b00,
    MGH_A_ASK  = 2'b01,
    MGH_A_OWN  = 2'b10,
    MGH_A_DROP = 2'b11
  } mgh_arb_t;

endpackage : mgh_pkg

`default_nettype wire

// *** mgh_glue_dummy_guard.sv ***
/*
  intentionally empty companion file: holds no logic.
  assumes nothing of its surroundings.
*/

// *** mgh_glue_chk.sv ***
/*
  concurrent checks on the ports of the multi graphics host glue.
  assumes the bind below attaches it to every mgh_glue instance.
*/
`timescale 1ns/1ns
`default_nettype none

module mgh_glue_chk (
  input wire logic                        sys_clk,
  input wire logic                        reset,
  input wire logic                        async_ready_input,
  input wire logic                        sel_port_wr,
  input wire logic [mgh_pkg::N_COP-1:0]   sel_port_wdata,
  input wire logic [mgh_pkg::N_COP-1:0]   sel_port_q,
  input wire logic                        broadcast_mode,
  input wire logic                        host_hold_req,
  input wire logic [mgh_pkg::ADDR_W-1:0]  cop_addr,
  input wire logic [mgh_pkg::N_COP-1:0]   cop_cs_n,
  input wire logic                        cop_rd_n,
  input wire logic                        cop_wr_n,
  input wire logic                        byte_high_enable_strap_o,
  input wire logic                        byte_high_enable_strap_oe,
  input wire logic [mgh_pkg::N_COP-1:0]   slave_enable_out,
  input wire logic [mgh_pkg::N_COP-1:0]   cop_hold_req,
  input wire logic [mgh_pkg::N_COP-1:0]   cop_hold_grant
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  AST_STRAP:
    assert property (disable iff (1'b0) reset |=> !byte_high_enable_strap_o
      && byte_high_enable_strap_oe) else $error("strap not low in reset");
  AST_ADDR_HOLD:
    assert property (!(&cop_cs_n) && !(&$past(cop_cs_n)) |-> $stable(cop_addr))
      else $error("address moved during access");
  AST_READY_LATE:
    assert property (async_ready_input |-> &$past(slave_enable_out | cop_cs_n, 4))
      else $error("ready before slave enables");
  AST_READY_PULSE:
    assert property (async_ready_input |=> !async_ready_input)
      else $error("ready longer than a cycle");
  AST_SEL:
    assert property (sel_port_wr |=> sel_port_q == $past(sel_port_wdata))
      else $error("select port not loaded");
  AST_WRITE_CS:
    assert property (!cop_wr_n |-> cop_cs_n == sel_port_q)
      else $error("write selects wrong units");
  AST_WAIT_ALL:
    assert property (async_ready_input |-> &(slave_enable_out | cop_cs_n))
      else $error("ready with a selected unit not ready");
  AST_READ_CS:
    assert property (!cop_rd_n |-> ~cop_cs_n == (~sel_port_q & (sel_port_q + 1'b1)))
      else $error("read selects wrong unit");
  AST_NO_MASTER:
    assert property (broadcast_mode |-> cop_hold_grant == '0)
      else $error("grant in broadcast scheme");
  AST_ONE_OWNER:
    assert property (|cop_hold_grant |-> $onehot(cop_hold_grant) && host_hold_req)
      else $error("grant not single or without hold");
  AST_KEEP:
    assert property (|$past(cop_hold_grant) && $changed(cop_hold_grant) |->
      cop_hold_grant == '0 && ($past(cop_hold_grant) & $past(cop_hold_req, 3)) == '0)
      else $error("grant moved while owner still asks");
endmodule : mgh_glue_chk

bind mgh_glue mgh_glue_chk i_mgh_glue_chk (.sys_clk, .reset, .async_ready_input,
  .sel_port_wr, .sel_port_wdata, .sel_port_q, .broadcast_mode, .host_hold_req,
  .cop_addr, .cop_cs_n, .cop_rd_n, .cop_wr_n, .byte_high_enable_strap_o,
  .byte_high_enable_strap_oe, .slave_enable_out, .cop_hold_req, .cop_hold_grant);

`default_nettype wire

// *** mgh_cop_model.sv ***
/*
  behavioural model of the coprocessors and the cpu hold grant.
  assumes its own clock is unrelated to sys_clk; slow picks late units.
*/
`timescale 1ns/1ns
`default_nettype none

module mgh_cop_model (
  input  wire logic                        reset,
  input  wire logic [mgh_pkg::N_COP-1:0]   cop_cs_n,
  input  wire logic                        cop_rd_n,
  input  wire logic                        cop_wr_n,
  input  wire logic                        strap,
  input  wire logic [mgh_pkg::N_COP-1:0]   slow,
  input  wire logic                        host_hold_req,
  output logic      [mgh_pkg::N_COP-1:0]   slave_enable_out,
  output logic      [mgh_pkg::DATA_W-1:0]  cop_rdata,
  output logic                             host_hold_grant,
  output logic                             async_mode
);
  logic       cop_clk = 1'b0;
  logic       pat_q   = 1'b0;
  logic [1:0] hg_q    = 2'b00;
  logic [3:0] cnt_q [mgh_pkg::N_COP];

  // own clock, no phase tie to the host
  always #6 cop_clk = ~cop_clk;
  // mode picked from the strap as reset falls
  always @(negedge reset) async_mode = !strap;
  // slave enable after a per-unit delay, dropped once deselected
  always @(posedge cop_clk) begin
    pat_q <= ~pat_q;
    hg_q  <= {hg_q[0], host_hold_req};
    for (int i = 0; i < mgh_pkg::N_COP; i++) begin
      if (cop_cs_n[i] || (cop_rd_n && cop_wr_n)) cnt_q[i] <= 4'h0;
      else if (cnt_q[i] != 4'hf) cnt_q[i] <= cnt_q[i] + 4'h1;
      slave_enable_out[i] <= !cop_cs_n[i] && (cnt_q[i] >= (slow[i] ? 4'h6 : 4'h1));
    end
  end
  assign host_hold_grant = hg_q[1];
  // idle bus toggles so a stale value never looks valid
  always_comb begin
    cop_rdata = {16{pat_q}};
    for (int i = 0; i < mgh_pkg::N_COP; i++)
      if (!cop_cs_n[i] && !cop_rd_n) cop_rdata = 16'hc0d0 + 16'(i);
  end
endmodule : mgh_cop_model

`default_nettype wire

// *** tb_mgh_glue.sv ***
/*
  self-checking bench for the multi graphics host glue.
  assumes mgh_cop_model stands for the coprocessors and the cpu hold logic.
*/
`timescale 1ns/1ns
`default_nettype none

module tb_mgh_glue;
  logic                        sys_clk = 1'b0, reset = 1'b1;
  logic                        cpu_addr_strobe = 1'b0, cpu_rd = 1'b0, cpu_wr = 1'b0;
  logic                        sel_port_wr = 1'b0, broadcast_mode = 1'b1;
  logic [mgh_pkg::ADDR_W-1:0]  cpu_addr = '0, cop_addr;
  logic [mgh_pkg::DATA_W-1:0]  cpu_wdata = '0, cpu_rdata, cop_wdata, cop_rdata, last_rd;
  logic [3:0]                  sel_port_wdata = 4'h0, cop_hold_req = 4'h0, slow = 4'h4;
  logic [3:0]                  sel_port_q, cop_cs_n, slave_enable_out, cop_hold_grant;
  logic                        async_ready_input, host_hold_req, host_hold_grant;
  logic                        cop_rd_n, cop_wr_n, strap_o, strap_oe, async_mode;
  int                          mismatches = 0, samples_checked = 0;

  mgh_glue i_mgh_glue (.sys_clk, .reset, .cpu_addr_strobe, .cpu_addr,
    .cpu_byte_high(1'b0), .cpu_rd, .cpu_wr, .cpu_wdata, .cpu_rdata, .async_ready_input,
    .sel_port_wr, .sel_port_wdata, .sel_port_q, .broadcast_mode, .host_hold_req,
    .host_hold_grant, .cop_addr, .cop_wdata, .cop_rdata, .cop_cs_n, .cop_rd_n, .cop_wr_n,
    .byte_high_enable_strap_o(strap_o), .byte_high_enable_strap_oe(strap_oe),
    .slave_enable_out, .cop_hold_req, .cop_hold_grant);
  mgh_cop_model i_mgh_cop_model (.reset, .cop_cs_n, .cop_rd_n, .cop_wr_n, .strap(strap_o),
    .slow, .host_hold_req, .slave_enable_out, .cop_rdata, .host_hold_grant, .async_mode);

  always #5 sys_clk = ~sys_clk;

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : tally_and_finish

  task automatic set_sel(input logic [3:0] v);
    sel_port_wr = 1'b1;
    sel_port_wdata = v;
    @(negedge sys_clk);
    sel_port_wr = 1'b0;
    chk("sel_port_q", sel_port_q, v);
  endtask : set_sel

  // cpu access; address withdrawn as the strobe falls, as a real cpu does
  task automatic acc(input logic wr, input logic [19:0] a, input logic [15:0] d,
                     input logic rdy, input logic [3:0] cs);
    int n;
    n = 0;
    cpu_addr_strobe = 1'b1;
    cpu_addr = a;
    @(negedge sys_clk);
    cpu_addr_strobe = 1'b0;
    cpu_addr = ~a;
    cpu_wdata = d;
    cpu_rd = !wr;
    cpu_wr = wr;
    while (async_ready_input !== 1'b1 && n < 60) begin
      @(negedge sys_clk);
      n++;
    end
    chk("ready", async_ready_input, rdy);
    chk("cs_n", cop_cs_n, cs);
    chk("all enables", slave_enable_out | cop_cs_n, 4'hf);
    chk("rd_n", cop_rd_n, !(rdy && !wr));
    chk("wr_n", cop_wr_n, !(rdy && wr));
    chk("cop_addr", cop_addr, a);
    if (wr) chk("cop_wdata", cop_wdata, d);
    if (cs != 4'hf) chk("late", n > 4, 1'b1);
    @(negedge sys_clk);
    last_rd = cpu_rdata;
    cpu_rd = 1'b0;
    cpu_wr = 1'b0;
    repeat (4) @(negedge sys_clk);
  endtask : acc

  task automatic wait_grant(input logic [3:0] v);
    int n;
    n = 0;
    while (cop_hold_grant !== v && n < 60) begin
      @(negedge sys_clk);
      n++;
    end
    chk("grant", cop_hold_grant, v);
  endtask : wait_grant

  task automatic t_broadcast_write;
    set_sel(4'b1010);
    acc(1'b1, 20'hc0124, 16'hbeef, 1'b1, 4'b1010);
    $display("done broadcast write");
  endtask : t_broadcast_write

  task automatic t_priority_read;
    set_sel(4'b1001);
    acc(1'b0, 20'hc0200, 16'h0, 1'b1, 4'b1101);
    chk("cpu_rdata", last_rd, 16'hc0d1);
    $display("done priority read");
  endtask : t_priority_read

  // nothing enabled, then an address outside the space
  task automatic t_edges;
    set_sel(4'hf);
    acc(1'b1, 20'hcfffe, 16'h1234, 1'b1, 4'hf);
    acc(1'b0, 20'h30000, 16'h0, 1'b0, 4'hf);
    $display("done edge accesses");
  endtask : t_edges

  task automatic t_arbiter;
    broadcast_mode = 1'b0;
    cop_hold_req = 4'b0110;
    wait_grant(4'b0010);
    chk("hold_req", host_hold_req, 1'b1);
    cop_hold_req = 4'b0111;
    repeat (10) @(negedge sys_clk);
    chk("grant kept", cop_hold_grant, 4'b0010);
    cop_hold_req = 4'b0101;
    wait_grant(4'b0000);
    wait_grant(4'b0001);
    cop_hold_req = 4'b0000;
    wait_grant(4'b0000);
    repeat (10) @(negedge sys_clk);
    chk("hold_req off", host_hold_req, 1'b0);
    broadcast_mode = 1'b1;
    $display("done arbiter");
  endtask : t_arbiter

  task automatic t_no_master;
    cop_hold_req = 4'b0001;
    repeat (40) @(negedge sys_clk);
    chk("grant", cop_hold_grant, 4'h0);
    chk("hold_req", host_hold_req, 1'b0);
    cop_hold_req = 4'b0000;
    $display("done slave only");
  endtask : t_no_master

  // watchdog sized well beyond the whole sequence
  initial begin
    repeat (20000) @(posedge sys_clk);
    mismatches++;
    tally_and_finish();
  end

  initial begin
    repeat (6) @(negedge sys_clk);
    chk("strap", strap_o, 1'b0);
    chk("strap oe", strap_oe, 1'b1);
    reset = 1'b0;
    @(negedge sys_clk);
    chk("async mode", async_mode, 1'b1);
    chk("sel reset", sel_port_q, 4'hf);
    t_broadcast_write();
    t_priority_read();
    t_edges();
    t_arbiter();
    t_no_master();
    tally_and_finish();
  end
endmodule : tb_mgh_glue

`default_nettype wire
